/* rtl/bm_pkg.sv */
/*
  Shared types and constants of the pack and rotate unit.
  Assumes a core whose register width is 64 bits and which can run
  either on the 32-bit or on the 64-bit base.
*/
package bm_pkg;

  localparam int XLEN     = 64;
  localparam int WORD_W   = 32;
  localparam int HALF_W   = 16;
  localparam int BYTE_W   = 8;
  localparam int SHAMT_W  = 6;
  localparam int WSHAMT_W = 5;
  localparam int XBYTES   = XLEN / BYTE_W;
  localparam int WBYTES   = WORD_W / BYTE_W;
  // Immediate bit that is reserved for full rotates on the 32-bit base
  localparam int RSV_SHAMT_BIT = 5;
  localparam logic [XLEN-1:0] RESULT_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [3:0] {
    OP_ORN   = 4'h0,
    OP_PACK  = 4'h1,
    OP_PACKH = 4'h2,
    OP_PACKW = 4'h3,
    OP_BSWAP = 4'h4,
    OP_BREV  = 4'h5,
    OP_ROL   = 4'h6,
    OP_ROLW  = 4'h7,
    OP_ROR   = 4'h8,
    OP_RORI  = 4'h9,
    OP_RORIW = 4'ha,
    OP_RORW  = 4'hb
  } op_t;

  typedef struct packed {
    logic                valid;
    op_t                 op;
    logic                base_64bit;
    logic [SHAMT_W-1:0]  imm_shamt;
    logic [XLEN-1:0]     first_source;
    logic [XLEN-1:0]     second_source;
  } req_t;

  typedef struct packed {
    logic                valid;
    logic                illegal;
    logic [XLEN-1:0]     result;
  } resp_t;

endpackage

/* rtl/rotate_core.sv */
/*
  Combinational rotator for full-width and word rotates.
  Assumes the caller picks the amount and sign-extends word results.
*/
`timescale 1ns/1ns
`default_nettype none

module rotate_core (
  // Operand and amount
  input  wire logic [bm_pkg::XLEN-1:0]    data,
  input  wire logic [bm_pkg::SHAMT_W-1:0] amount,
  // Direction and width
  input  wire logic                       left,
  input  wire logic                       word,
  // Rotated value, word result zero-extended
  output logic      [bm_pkg::XLEN-1:0]    rotated
);
  import bm_pkg::*;

  logic [2*XLEN-1:0]   dbl_x;
  logic [2*WORD_W-1:0] dbl_w;
  logic [WSHAMT_W-1:0] amt_w;

  // Doubling the operand turns a rotate into one shift and a slice
  always_comb begin
    dbl_x = '0;
    dbl_w = '0;
    amt_w = amount[WSHAMT_W-1:0];
    if (word) begin
      if (left) begin
        dbl_w = {data[WORD_W-1:0], data[WORD_W-1:0]} << amt_w;
        rotated = {{(XLEN-WORD_W){1'b0}}, dbl_w[2*WORD_W-1:WORD_W]};
      end else begin
        dbl_w = {data[WORD_W-1:0], data[WORD_W-1:0]} >> amt_w;
        rotated = {{(XLEN-WORD_W){1'b0}}, dbl_w[WORD_W-1:0]};
      end
    end else begin
      if (left) begin
        dbl_x = {data, data} << amount;
        rotated = dbl_x[2*XLEN-1:XLEN];
      end else begin
        dbl_x = {data, data} >> amount;
        rotated = dbl_x[XLEN-1:0];
      end
    end
  end

endmodule // rotate_core

`default_nettype wire

/* rtl/bitmanip_pack_rotate_unit.sv */
/*
  Bit-manipulation execute unit: or-not, packing, byte and bit order
  swaps and rotates, one operation per cycle, result one edge later.
  Assumes the core has read the sources (zero register reads as zero)
  and already weeds out illegal encodings.
*/
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Or-not: first source or inverted second
// - Pack low halves, first low, second high
// - Pack with zero register zero-extends halfword on 32-bit base, word on 64-bit
// - Pack low bytes into bits 15..0
// - Word pack of halfwords, sign-extend bit 31
// - Word pack exists only on 64-bit base
// - Word pack with zero register zero-extends
// - Byte order swap reverses all bytes
// - Byte swap decoded on both bases
// - Byte swap is always full width
// - Reverse bits inside every byte
// - Rotate left by low log2 width bits
// - Word rotate left, sign-extend bit 31
// - Rotate right by low log2 width bits
// - Immediate rotate right, bit 5 reserved on 32-bit
// - Immediate word rotate right, sign-extend
// - Register word rotate right, sign-extend

module bitmanip_pack_rotate_unit (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          srst,
  // Operation from register read
  input  wire bm_pkg::req_t  req,
  // Result to writeback
  output var  bm_pkg::resp_t resp_r
);
  import bm_pkg::*;

  function automatic logic [XLEN-1:0] sext_word(input logic [WORD_W-1:0] w);
    return {{(XLEN-WORD_W){w[WORD_W-1]}}, w};
  endfunction

  // On the 32-bit base the upper half of the result is kept at zero
  function automatic logic [XLEN-1:0] fit_base(input logic [XLEN-1:0] d,
                                               input logic            b64);
    return b64 ? d : {{(XLEN-WORD_W){1'b0}}, d[WORD_W-1:0]};
  endfunction

  function automatic logic [XLEN-1:0] byte_swap(input logic [XLEN-1:0] d,
                                                input logic            b64);
    logic [XLEN-1:0] r;
    r = '0;
    if (b64) begin
      for (int k = 0; k < XBYTES; k++) begin
        r[k*BYTE_W +: BYTE_W] = d[(XBYTES-1-k)*BYTE_W +: BYTE_W];
      end
    end else begin
      for (int k = 0; k < WBYTES; k++) begin
        r[k*BYTE_W +: BYTE_W] = d[(WBYTES-1-k)*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction

  function automatic logic [XLEN-1:0] bit_swap(input logic [XLEN-1:0] d);
    logic [XLEN-1:0] r;
    r = '0;
    for (int k = 0; k < XBYTES; k++) begin
      for (int b = 0; b < BYTE_W; b++) begin
        r[k*BYTE_W+b] = d[k*BYTE_W+BYTE_W-1-b];
      end
    end
    return r;
  endfunction

  logic               rot_left;
  logic               rot_word;
  logic [SHAMT_W-1:0] rot_amount;
  logic [XLEN-1:0]    rotated;
  logic [XLEN-1:0]    result_nxt;
  logic               illegal_nxt;
  logic [XLEN-1:0]    a;
  logic [XLEN-1:0]    b;
  logic               b64;

  assign a   = req.first_source;
  assign b   = req.second_source;
  assign b64 = req.base_64bit;

  // Rotator steering
  always_comb begin
    rot_left   = (req.op == OP_ROL) || (req.op == OP_ROLW);
    // Full rotates on the 32-bit base are word rotates there
    rot_word   = !b64 || (req.op == OP_ROLW) || (req.op == OP_RORW)
                 || (req.op == OP_RORIW);
    unique case (req.op)
      OP_RORI, OP_RORIW: rot_amount = req.imm_shamt;
      default:           rot_amount = b[SHAMT_W-1:0];
    endcase
  end

  rotate_core u_rotate (
    .data    (a),
    .amount  (rot_amount),
    .left    (rot_left),
    .word    (rot_word),
    .rotated (rotated)
  );

  // Result selection
  always_comb begin
    illegal_nxt = 1'b0;
    unique case (req.op)
      OP_ORN: begin
        result_nxt = fit_base(a | ~b, b64);
      end
      OP_PACK: begin
        // A zero second source leaves a zero-extended halfword on the 32-bit base, a word on the 64-bit base
        if (b64) begin
          result_nxt = {b[WORD_W-1:0], a[WORD_W-1:0]};
        end else begin
          result_nxt = {{(XLEN-WORD_W){1'b0}},
                        b[HALF_W-1:0], a[HALF_W-1:0]};
        end
      end
      OP_PACKH: begin
        result_nxt = {{(XLEN-2*BYTE_W){1'b0}},
                      b[BYTE_W-1:0], a[BYTE_W-1:0]};
      end
      OP_PACKW: begin
        if (b64) begin
          result_nxt = sext_word({b[HALF_W-1:0], a[HALF_W-1:0]});
        end else begin
          result_nxt  = RESULT_RST;
          illegal_nxt = 1'b1;
        end
      end
      OP_BSWAP: begin
        result_nxt = byte_swap(a, b64);
      end
      OP_BREV: begin
        result_nxt = fit_base(bit_swap(a), b64);
      end
      OP_ROL, OP_ROR: begin
        result_nxt = rotated;
      end
      OP_RORI: begin
        // Defensive: the core should never send this, see the flag
        if (!b64 && req.imm_shamt[RSV_SHAMT_BIT]) begin
          result_nxt  = RESULT_RST;
          illegal_nxt = 1'b1;
        end else begin
          result_nxt = rotated;
        end
      end
      OP_ROLW, OP_RORW, OP_RORIW: begin
        result_nxt = fit_base(sext_word(rotated[WORD_W-1:0]), b64);
      end
      default: begin
        result_nxt  = RESULT_RST;
        illegal_nxt = 1'b1;
      end
    endcase
  end

  // One register stage only; nothing survives from one operation to the next
  always_ff @(posedge clock) begin
    if (srst) begin
      resp_r <= '{valid: 1'b0, illegal: 1'b0, result: RESULT_RST};
    end else begin
      resp_r.valid   <= req.valid;
      resp_r.illegal <= req.valid && illegal_nxt;
      resp_r.result  <= req.valid ? result_nxt : RESULT_RST;
    end
  end

  // Checks
  req_t prv_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      prv_r <= '0;
    end else begin
      prv_r <= req;
    end
  end

  logic [XLEN-1:0] pa;
  logic [XLEN-1:0] pb;
  logic [WORD_W-1:0] pw;
  logic            done;

  assign pa   = prv_r.first_source;
  assign pb   = prv_r.second_source;
  assign pw   = pa[WORD_W-1:0];
  assign done = resp_r.valid && prv_r.base_64bit;

  // Reference reorderings for the swap checks, kept out of the properties
  // since streamed values may not stand as operands there
  logic [XLEN-1:0]   swap_pa;
  logic [WORD_W-1:0] swap_pw;
  logic [XLEN-1:0]   swap_res;
  logic [XLEN-1:0]   flip_pa;

  assign swap_pa  = {<<BYTE_W{pa}};
  assign swap_pw  = {<<BYTE_W{pw}};
  assign swap_res = {<<BYTE_W{resp_r.result}};
  assign flip_pa  = {<<{pa}};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_orn;
    done && prv_r.op == OP_ORN |-> resp_r.result == ~(~pa & pb);
  endproperty
  a_orn: assert property (p_orn) else $error("or-not mismatch");

  property p_pack;
    done && prv_r.op == OP_PACK
      |-> resp_r.result[WORD_W-1:0] == pa[WORD_W-1:0]
       && resp_r.result[XLEN-1:WORD_W] == pb[WORD_W-1:0];
  endproperty
  a_pack: assert property (p_pack) else $error("pack mismatch");

  property p_pack_zext;
    resp_r.valid && !prv_r.base_64bit && prv_r.op == OP_PACK && pb == '0
      |-> resp_r.result == XLEN'(pa[HALF_W-1:0]);
  endproperty
  a_pack_zext: assert property (p_pack_zext) else $error("pack zext wrong");

  property p_packh;
    resp_r.valid && prv_r.op == OP_PACKH
      |-> resp_r.result == ((XLEN'(pb[BYTE_W-1:0]) << BYTE_W)
                            | XLEN'(pa[BYTE_W-1:0]));
  endproperty
  a_packh: assert property (p_packh) else $error("pack bytes mismatch");

  property p_packw;
    done && prv_r.op == OP_PACKW
      |-> resp_r.result[HALF_W-1:0] == pa[HALF_W-1:0]
       && resp_r.result[WORD_W-1:HALF_W] == pb[HALF_W-1:0]
       && resp_r.result[XLEN-1:WORD_W] == {WORD_W{pb[HALF_W-1]}};
  endproperty
  a_packw: assert property (p_packw) else $error("word pack mismatch");

  property p_packw_b32;
    !srst && req.valid && !req.base_64bit && req.op == OP_PACKW
      |=> resp_r.illegal && resp_r.result == '0;
  endproperty
  a_packw_b32: assert property (p_packw_b32) else $error("word pack on 32");

  property p_packw_zext;
    done && prv_r.op == OP_PACKW && pb == '0
      |-> resp_r.result == XLEN'(pa[HALF_W-1:0]);
  endproperty
  a_packw_zext: assert property (p_packw_zext) else $error("word pack zext");

  property p_bswap;
    done && prv_r.op == OP_BSWAP |-> resp_r.result == swap_pa;
  endproperty
  a_bswap: assert property (p_bswap) else $error("byte swap mismatch");

  property p_bswap_b32;
    resp_r.valid && !prv_r.base_64bit && prv_r.op == OP_BSWAP
      |-> resp_r.result == XLEN'(swap_pw);
  endproperty
  a_bswap_b32: assert property (p_bswap_b32) else $error("32-bit swap");

  property p_bswap_full;
    done && prv_r.op == OP_BSWAP
      |-> resp_r.result[BYTE_W-1:0] == pa[XLEN-1:XLEN-BYTE_W];
  endproperty
  a_bswap_full: assert property (p_bswap_full) else $error("swap not full");

  property p_brev;
    done && prv_r.op == OP_BREV
      |-> swap_res == flip_pa;
  endproperty
  a_brev: assert property (p_brev) else $error("bit swap mismatch");

  property p_rol;
    done && prv_r.op == OP_ROL
      |-> resp_r.result == ((pa << pb[SHAMT_W-1:0])
                            | (pa >> (7'd64 - {1'b0, pb[SHAMT_W-1:0]})));
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left mismatch");

  property p_rol_b32;
    resp_r.valid && !prv_r.base_64bit && prv_r.op == OP_ROL
      |-> resp_r.result == XLEN'(WORD_W'((pw << pb[WSHAMT_W-1:0])
                          | (pw >> (6'd32 - {1'b0, pb[WSHAMT_W-1:0]}))));
  endproperty
  a_rol_b32: assert property (p_rol_b32) else $error("32-bit rotate left");

  property p_rolw;
    done && prv_r.op == OP_ROLW
      |-> resp_r.result == sext_word((pw << pb[WSHAMT_W-1:0])
                          | (pw >> (6'd32 - {1'b0, pb[WSHAMT_W-1:0]})));
  endproperty
  a_rolw: assert property (p_rolw) else $error("word rotate left");

  property p_ror;
    done && prv_r.op == OP_ROR
      |-> resp_r.result == ((pa >> pb[SHAMT_W-1:0])
                            | (pa << (7'd64 - {1'b0, pb[SHAMT_W-1:0]})));
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right mismatch");

  property p_rori_rsv;
    !srst && req.valid && !req.base_64bit && req.op == OP_RORI
      && req.imm_shamt[RSV_SHAMT_BIT] |=> resp_r.illegal;
  endproperty
  a_rori_rsv: assert property (p_rori_rsv) else $error("reserved rotate");

  property p_roriw;
    done && prv_r.op == OP_RORIW
      |-> resp_r.result == sext_word((pw >> prv_r.imm_shamt[WSHAMT_W-1:0])
                 | (pw << (6'd32 - {1'b0, prv_r.imm_shamt[WSHAMT_W-1:0]})));
  endproperty
  a_roriw: assert property (p_roriw) else $error("imm word rotate");

  property p_rorw;
    done && prv_r.op == OP_RORW
      |-> resp_r.result == sext_word((pw >> pb[WSHAMT_W-1:0])
                          | (pw << (6'd32 - {1'b0, pb[WSHAMT_W-1:0]})));
  endproperty
  a_rorw: assert property (p_rorw) else $error("word rotate right");

  property p_one_cycle;
    !srst && req.valid ##1 !srst && !req.valid
      |-> resp_r.valid ##1 !resp_r.valid && resp_r.result == '0;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("latency off");

  c_packw_neg:  cover property (done && prv_r.op == OP_PACKW && pb[HALF_W-1]);
  c_rori_b32:   cover property (resp_r.valid && !prv_r.base_64bit
                                && prv_r.op == OP_RORI);
  c_bswap_both: cover property (done && prv_r.op == OP_BSWAP ##1
                                resp_r.valid && prv_r.op == OP_BSWAP
                                && !prv_r.base_64bit);
  c_rolw_zero:  cover property (done && prv_r.op == OP_ROLW
                                && pb[WSHAMT_W-1:0] == '0);

endmodule // bitmanip_pack_rotate_unit

`default_nettype wire

/* dv/core_side_model.sv */
/*
  Model of the core side that feeds the pack and rotate unit:
  decode and register read hand it one request per cycle.
  Assumes the bench calls its tasks from one process, in order.
*/
`timescale 1ns/1ns
`default_nettype none

module core_side_model (
  // Core clock
  input  wire logic         clock,
  // Request into the unit
  output var  bm_pkg::req_t req
);
  import bm_pkg::*;

  initial req = '0;

  // Reserved encodings are sent only where the bench exercises a refusal
  task automatic issue(input op_t op, input logic b64, input logic [5:0] imm,
                       input logic [63:0] a, input logic [63:0] b);
    @(posedge clock);
    req <= '{valid: 1'b1, op: op, base_64bit: b64, imm_shamt: imm,
             first_source: a, second_source: b};
  endtask

  // Idle cycles still carry junk operands, so valid must gate everything
  task automatic idle();
    @(posedge clock);
    req <= '{valid: 1'b0, op: op_t'(4'($urandom)), base_64bit: 1'($urandom),
             imm_shamt: 6'($urandom), first_source: {$urandom, $urandom},
             second_source: {$urandom, $urandom}};
  endtask
endmodule // core_side_model

`default_nettype wire

/* dv/tb.sv */
/*
  Self-checking bench of the pack and rotate unit: a reference model
  predicts every result, one edge after each request.
  Assumes the core side model drives the request port.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  import bm_pkg::*;

  logic          clock;
  logic          srst;
  req_t          req;
  resp_t         resp_r;
  logic [65:0]   exp_q[$];
  logic [65:0]   exp_r;
  logic          started    = 1'b0;
  logic          last_valid = 1'b0;
  op_t           last_op    = OP_ORN;
  int            num_errors;
  int            checks;

  core_side_model u_core (.clock(clock), .req(req));
  bitmanip_pack_rotate_unit u_dut (.clock(clock), .srst(srst), .req(req), .resp_r(resp_r));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  function automatic logic [63:0] rot(input logic [63:0] x, input int n, input int w);
    logic [63:0] y;
    y = '0;
    for (int i = 0; i < w; i++) y[(i + n) % w] = x[i];
    return y;
  endfunction

  function automatic logic [63:0] fin(input logic [63:0] x, input logic b64);
    return b64 ? {{32{x[31]}}, x[31:0]} : {32'h0, x[31:0]};
  endfunction

  function automatic logic [65:0] model(input req_t r);
    int          w;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] y;
    logic        ill;
    if (!r.valid) return '0;
    w = r.base_64bit ? 64 : 32;
    a = r.first_source;
    b = r.second_source;
    y = '0;
    ill = 1'b0;
    if (w == 32) a[63:32] = '0;
    case (r.op)
      OP_ORN:   y = a | ~b;
      OP_PACK:  y = r.base_64bit ? {b[31:0], a[31:0]} : {32'h0, b[15:0], a[15:0]};
      OP_PACKH: y = {48'h0, b[7:0], a[7:0]};
      OP_PACKW: if (r.base_64bit) y = fin({32'h0, b[15:0], a[15:0]}, 1'b1); else ill = 1'b1;
      OP_BSWAP: for (int k = 0; k < w / 8; k++) y[8*k +: 8] = a[8*(w/8-1-k) +: 8];
      OP_BREV:  for (int k = 0; k < w; k++) y[k] = a[(k / 8) * 8 + 7 - k % 8];
      OP_ROL:   y = rot(a, int'(b[5:0]) % w, w);
      OP_ROLW:  y = fin(rot(a, int'(b[4:0]), 32), r.base_64bit);
      OP_ROR:   y = rot(a, w - int'(b[5:0]) % w, w);
      OP_RORI:  if (!r.base_64bit && r.imm_shamt[5]) ill = 1'b1;
                else y = rot(a, w - int'(r.imm_shamt) % w, w);
      OP_RORIW: y = fin(rot(a, 32 - int'(r.imm_shamt[4:0]), 32), r.base_64bit);
      OP_RORW:  y = fin(rot(a, 32 - int'(b[4:0]), 32), r.base_64bit);
      default:  ill = 1'b1;
    endcase
    // On the 32-bit base nothing lands above bit 31
    if (w == 32) y[63:32] = '0;
    if (ill) y = '0;
    return {1'b1, ill, y};
  endfunction

  task automatic check(input string name, input logic [65:0] exp, input logic [65:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  always @(posedge clock) begin
    started <= started | srst;
    exp_q.push_back(srst ? 66'h0 : model(req));
    last_valid <= req.valid & ~srst;
    last_op <= req.op;
  end

  // Sampled mid-cycle, well clear of the launching edge
  always @(negedge clock) begin
    if (started && exp_q.size() != 0) begin
      exp_r = exp_q.pop_front();
      if (!last_valid) check("idle", exp_r, resp_r);
      else case (last_op)
        OP_ORN:   check("orn", exp_r, resp_r);
        OP_PACK:  check("pack", exp_r, resp_r);
        OP_PACKH: check("packh", exp_r, resp_r);
        OP_PACKW: check("packw", exp_r, resp_r);
        OP_BSWAP: check("bswap", exp_r, resp_r);
        OP_BREV:  check("brev", exp_r, resp_r);
        OP_ROL:   check("rol", exp_r, resp_r);
        OP_ROLW:  check("rolw", exp_r, resp_r);
        OP_ROR:   check("ror", exp_r, resp_r);
        OP_RORI:  check("rori", exp_r, resp_r);
        OP_RORIW: check("roriw", exp_r, resp_r);
        OP_RORW:  check("rorw", exp_r, resp_r);
        default:  check("undefined", exp_r, resp_r);
      endcase
    end
  end

  function automatic logic [63:0] rnd64();
    return {$urandom, $urandom};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #40000;
    num_errors++;
    summarize();
  end

  initial begin
    int amt[6];
    srst = 1'b1;
    num_errors = 0;
    checks = 0;
    amt = '{0, 1, 31, 32, 63, 69};
    void'($urandom(32'hb5a429a4));
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    repeat (3) u_core.idle();
    $display("test reset done");
    for (int b = 0; b < 2; b++) begin
      for (int o = 0; o < 16; o++) begin
        u_core.issue(op_t'(o), 1'(b), 6'($urandom), rnd64(), rnd64());
      end
    end
    u_core.idle();
    $display("test all_ops done");
    u_core.issue(OP_PACK, 1'b0, 6'h0, rnd64(), 64'h0);
    u_core.issue(OP_PACKW, 1'b1, 6'h0, 64'hffff_ffff_ffff_8001, 64'h0);
    u_core.issue(OP_PACKW, 1'b1, 6'h0, rnd64(), 64'hffff_ffff_ffff_8000);
    u_core.issue(OP_PACKW, 1'b0, 6'h0, rnd64(), rnd64());
    u_core.issue(OP_BSWAP, 1'b1, 6'h0, rnd64(), rnd64());
    u_core.issue(OP_BSWAP, 1'b0, 6'h0, rnd64(), rnd64());
    u_core.idle();
    $display("test aliases done");
    for (int i = 0; i < 6; i++) begin
      for (int b = 0; b < 2; b++) begin
        u_core.issue(OP_ROL, 1'(b), 6'h0, rnd64(), 64'(amt[i]));
        u_core.issue(OP_ROR, 1'(b), 6'h0, rnd64(), 64'(amt[i]));
        u_core.issue(OP_ROLW, 1'(b), 6'h0, 64'h8000_0001, 64'(amt[i]));
        u_core.issue(OP_RORW, 1'(b), 6'h0, 64'h0000_0003, 64'(amt[i]));
      end
    end
    for (int s = 0; s < 64; s++) begin
      u_core.issue(OP_RORI, 1'(s), 6'(s), rnd64(), rnd64());
      u_core.issue(OP_RORIW, 1'(s >> 1), 6'(s), 64'h0000_0001, rnd64());
    end
    u_core.idle();
    $display("test amounts done");
    for (int i = 0; i < 400; i++) begin
      if ($urandom % 4 == 0) u_core.idle();
      else u_core.issue(op_t'(4'($urandom)), 1'($urandom), 6'($urandom), rnd64(), rnd64());
    end
    u_core.idle();
    $display("test random done");
    // A request that meets reset must leave nothing behind
    u_core.issue(OP_BSWAP, 1'b1, 6'h0, rnd64(), rnd64());
    srst <= 1'b1;
    u_core.issue(OP_ORN, 1'b1, 6'h0, rnd64(), rnd64());
    u_core.idle();
    srst <= 1'b0;
    u_core.issue(OP_BREV, 1'b0, 6'h0, rnd64(), rnd64());
    repeat (3) u_core.idle();
    $display("test reset_mid done");
    summarize();
  end
endmodule // tb

`default_nettype wire
